//--- bafe_host.sv
// Host model: AXI4-Lite master making one access at a time
`timescale 1ns/1ps
module bafe_host (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int hangs = 0;
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    wstrb = 4'h1;
  end
  task automatic wr(input logic [7:0] a, v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    // Reserved control one and short-circuit protection bits always go out as zero
    wdata <= {24'h0, v & (a == 8'h10 ? 8'hFB : a == 8'h18 ? 8'hDF : 8'hFF)};
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && n < 99);
    r = bresp;
    bready <= 1'b0;
    if (n >= 99) hangs++;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && n < 99);
    {v, r} = {rdata, rresp};
    rready <= 1'b0;
    if (n >= 99) hangs++;
  endtask : rd
endmodule : bafe_host

//--- bafe_pkg.sv
// Package with register map, field positions, tables and timing for the battery AFE register bank
package bafe_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned CC_PERIOD_MS = 250;
  localparam int unsigned CC_PERIOD_CYCLES = CC_PERIOD_MS * (CLK_HZ / 1000);

  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_BAL_LOW = 3'h1;
  localparam logic [2:0] IDX_BAL_MID = 3'h2;
  localparam logic [2:0] IDX_BAL_HIGH = 3'h3;
  localparam logic [2:0] IDX_CTRL_ONE = 3'h4;
  localparam logic [2:0] IDX_CTRL_TWO = 3'h5;
  localparam logic [2:0] IDX_SC_PROT = 3'h6;
  localparam logic [2:0] IDX_OC_PROT = 3'h7;
  localparam int unsigned REG_COUNT = 8;

  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [4:0] BAL_MASK = 5'h1F;

  // Status bits
  localparam int unsigned ST_READY = 7;
  localparam int unsigned ST_FAULT = 5;
  localparam int unsigned ST_ALERT = 4;
  localparam int unsigned ST_UV = 3;
  localparam int unsigned ST_OV = 2;
  localparam int unsigned ST_SC = 1;
  localparam int unsigned ST_OC = 0;
  localparam logic [7:0] STATUS_MASK = 8'hBF;

  // Control one bits
  localparam int unsigned C1_LOAD = 7;
  localparam int unsigned C1_ADC = 4;
  localparam int unsigned C1_TEMP = 3;
  localparam int unsigned C1_RSVD = 2;
  localparam int unsigned C1_SHUT_A = 1;
  localparam int unsigned C1_SHUT_B = 0;

  // Control two bits
  localparam int unsigned C2_BYPASS = 7;
  localparam int unsigned C2_CONT = 6;
  localparam int unsigned C2_SINGLE = 5;
  localparam int unsigned C2_RSVD_HI = 4;
  localparam int unsigned C2_RSVD_LO = 2;
  localparam int unsigned C2_DSG = 1;
  localparam int unsigned C2_CHG = 0;

  // Protection fields
  localparam int unsigned P1_RANGE = 7;
  localparam int unsigned P1_RSVD = 5;
  localparam int unsigned P1_SCD_HI = 4;
  localparam int unsigned P1_SCD_LO = 3;
  localparam int unsigned P1_SCT_HI = 2;
  localparam int unsigned P2_OCD_HI = 6;
  localparam int unsigned P2_OCD_LO = 4;
  localparam int unsigned P2_OCT_HI = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam logic [7:0] SC_UPPER_MV [8] = '{8'h2C, 8'h43, 8'h59, 8'h6F, 8'h85, 8'h9B, 8'hB2, 8'hC8};
  localparam logic [7:0] SC_LOWER_MV [8] = '{8'h16, 8'h21, 8'h2C, 8'h38, 8'h43, 8'h4E, 8'h59, 8'h64};
  localparam logic [7:0] OC_UPPER_MV [16] = '{8'h11, 8'h16, 8'h1C, 8'h21, 8'h27, 8'h2C, 8'h32,
    8'h38, 8'h3D, 8'h43, 8'h48, 8'h4E, 8'h53, 8'h59, 8'h5E, 8'h64};
  localparam logic [7:0] OC_LOWER_MV [16] = '{8'h08, 8'h0B, 8'h0E, 8'h11, 8'h13, 8'h16, 8'h19,
    8'h1C, 8'h1F, 8'h21, 8'h24, 8'h27, 8'h2A, 8'h2C, 8'h2F, 8'h32};
  localparam logic [10:0] OC_DELAY_MS [8] = '{11'h008, 11'h014, 11'h028, 11'h050,
    11'h0A0, 11'h140, 11'h280, 11'h500};
  localparam logic [17:0] SC_DELAY_US [4] = '{18'h00046, 18'h00064, 18'h000C8, 18'h00190};
  localparam logic [10:0] BYPASS_DELAY_MS = 11'h0FA;
  localparam logic [17:0] BYPASS_DELAY_US = 18'h3D090;

  typedef enum logic [1:0] {
    BAFE_SHUT_START,
    BAFE_SHUT_ARMED,
    BAFE_SHUT_IGNORED
  } bafe_shut_t;
endpackage : bafe_pkg

//--- bafe_regs.sv
// Control and status register bank of the battery monitor front end, AXI4-Lite slave
`timescale 1ns/1ps
// Functional notes
// - Status flags clear on write-one, zero keeps
// - Result-ready sets per result, host only clears
// - Internal fault latches; host clears after waiting
// - Alert override latches only when not self-driven
// - Each protection fault latches its own bit
// - Three balance registers, five cell enables each
// - Load-present reads charge pin level, driver off
// - ADC enable gates conversions and overvoltage protection
// - Temperature select: die or thermistor source
// - Shutdown only after 00, 01, 10 sequence
// - Delay bypass forces roughly 250 ms delays
// - Continuous counting ignores the single trigger
// - Single trigger: one 250 ms run, then ready
// - Trigger only when idle and ready clear
// - Control two drives discharge and charge outputs
// - Range bit doubles overcurrent and short thresholds
// - Short-circuit delay code picks 70 to 400 us
// - Short-circuit threshold code picks eight levels
// - Overcurrent delay code picks 8 to 1280 ms
// - Overcurrent threshold code picks sixteen levels
module bafe_regs #(
  parameter int unsigned ADDR_W           = 8,
  parameter int unsigned CC_PERIOD_CYCLES = bafe_pkg::CC_PERIOD_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  input  wire logic              internal_fault_event,
  input  wire logic              undervoltage_event,
  input  wire logic              overvoltage_event,
  input  wire logic              short_circuit_event,
  input  wire logic              overcurrent_event,
  input  wire logic              alert_pin_level,
  input  wire logic              alert_self_drive,
  input  wire logic              charge_pin_above_load,
  output logic [14:0]            cell_balance_enable,
  output logic                   conversions_enable,
  output logic                   overvoltage_protect_enable,
  output logic                   temp_source_thermistor,
  output logic                   shutdown_request,
  output logic                   counter_active,
  output logic                   discharge_driver_output,
  output logic                   charge_driver_output,
  output logic                   threshold_range_select,
  output logic [17:0]            short_circuit_delay_us,
  output logic [7:0]             short_circuit_threshold_mv,
  output logic [10:0]            overcurrent_delay_ms,
  output logic [7:0]             overcurrent_threshold_mv
);

  localparam int unsigned CNT_W = $clog2(CC_PERIOD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CC_PERIOD_CYCLES - 1);

  function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
    addr_ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:2] < (ADDR_W-2)'(bafe_pkg::REG_COUNT));
  endfunction : addr_ok

  function automatic logic [2:0] addr_idx(input logic [ADDR_W-1:0] a);
    addr_idx = a[4:2];
  endfunction : addr_idx

  logic [7:0]         status;
  logic [4:0]         bal_low;
  logic [4:0]         bal_mid;
  logic [4:0]         bal_high;
  logic               load_present;
  logic               adc_en;
  logic               temp_sel;
  logic               c1_rsvd;
  logic [1:0]         shut_bits;
  logic               delay_bypass;
  logic               cc_continuous;
  logic               cc_trigger;
  logic [2:0]         c2_rsvd;
  logic               discharge_driver_on;
  logic               charge_driver_on;
  logic [7:0]         sc_prot;
  logic [6:0]         oc_prot;
  bafe_pkg::bafe_shut_t shut_state;
  logic [CNT_W-1:0]   cc_count;

  logic               aw_full;
  logic               w_full;
  logic [ADDR_W-1:0]  aw_addr_q;
  logic [7:0]         wbyte;
  logic               wlane;
  logic               wr_fire;
  logic               wr_ok;
  logic [2:0]         wr_idx;
  logic               cc_run;
  logic               cc_done;
  logic [7:0]         rd_value;
  logic [7:0]         status_set;
  logic [7:0]         status_clr;

  assign wr_fire = aw_full && w_full && !bvalid;
  assign wr_ok   = wr_fire && addr_ok(aw_addr_q) && wlane;
  assign wr_idx  = addr_idx(aw_addr_q);
  assign cc_run  = cc_continuous || cc_trigger;
  assign cc_done = cc_run && (cc_count == CNT_LAST);

  // Write address and data taken in either order, response after both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      aw_full   <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      awready   <= 1'b0;
      aw_full   <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_fire) begin
      aw_full <= 1'b0;
    end else if (!aw_full && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b0;
      w_full <= 1'b0;
      wbyte  <= bafe_pkg::RESET_BYTE;
      wlane  <= 1'b0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_full <= 1'b1;
      wbyte  <= wdata[7:0];
      wlane  <= wstrb[0];
    end else if (wr_fire) begin
      w_full <= 1'b0;
    end else if (!w_full && !bvalid) begin
      wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= bafe_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= addr_ok(aw_addr_q) ? bafe_pkg::RESP_OKAY : bafe_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read value; unnamed bits stay zero
  always_comb begin
    rd_value = bafe_pkg::RESET_BYTE;
    case (addr_idx(araddr))
      bafe_pkg::IDX_STATUS:   rd_value = status & bafe_pkg::STATUS_MASK;
      bafe_pkg::IDX_BAL_LOW:  rd_value = {3'h0, bal_low};
      bafe_pkg::IDX_BAL_MID:  rd_value = {3'h0, bal_mid};
      bafe_pkg::IDX_BAL_HIGH: rd_value = {3'h0, bal_high};
      bafe_pkg::IDX_CTRL_ONE: rd_value = {load_present, 2'h0, adc_en, temp_sel, c1_rsvd, shut_bits};
      bafe_pkg::IDX_CTRL_TWO: rd_value = {delay_bypass, cc_continuous, cc_trigger, c2_rsvd,
                                          discharge_driver_on, charge_driver_on};
      bafe_pkg::IDX_SC_PROT:  rd_value = {sc_prot[7], 1'b0, sc_prot[5:0]};
      bafe_pkg::IDX_OC_PROT:  rd_value = {1'b0, oc_prot};
      default:                rd_value = bafe_pkg::RESET_BYTE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= bafe_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= addr_ok(araddr) ? {24'h000000, rd_value} : 32'h00000000;
      rresp   <= addr_ok(araddr) ? bafe_pkg::RESP_OKAY : bafe_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Status flags: a set in the clearing cycle wins
  always_comb begin
    status_set = 8'h00;
    status_clr = 8'h00;
    status_set[bafe_pkg::ST_READY] = cc_done;
    status_set[bafe_pkg::ST_FAULT] = internal_fault_event;
    status_set[bafe_pkg::ST_ALERT] = alert_pin_level && !alert_self_drive;
    status_set[bafe_pkg::ST_UV]    = undervoltage_event;
    status_set[bafe_pkg::ST_OV]    = overvoltage_event && adc_en;
    status_set[bafe_pkg::ST_SC]    = short_circuit_event;
    status_set[bafe_pkg::ST_OC]    = overcurrent_event;
    if (wr_ok && wr_idx == bafe_pkg::IDX_STATUS) begin
      status_clr = wbyte & bafe_pkg::STATUS_MASK;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status <= bafe_pkg::RESET_BYTE;
    end else begin
      status <= ((status & ~status_clr) | status_set) & bafe_pkg::STATUS_MASK;
    end
  end

  // Balance enables and protection settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bal_low  <= '0;
      bal_mid  <= '0;
      bal_high <= '0;
      sc_prot  <= bafe_pkg::RESET_BYTE;
      oc_prot  <= '0;
    end else if (wr_ok) begin
      case (wr_idx)
        bafe_pkg::IDX_BAL_LOW:  bal_low <= wbyte[4:0] & bafe_pkg::BAL_MASK;
        bafe_pkg::IDX_BAL_MID:  bal_mid <= wbyte[4:0] & bafe_pkg::BAL_MASK;
        bafe_pkg::IDX_BAL_HIGH: bal_high <= wbyte[4:0] & bafe_pkg::BAL_MASK;
        bafe_pkg::IDX_SC_PROT:  sc_prot <= {wbyte[7], 1'b0, wbyte[5:0]};
        bafe_pkg::IDX_OC_PROT:  oc_prot <= wbyte[6:0];
        default: ;
      endcase
    end
  end

  // Control one; reserved bit stored as the host leaves it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      adc_en    <= 1'b0;
      temp_sel  <= 1'b0;
      c1_rsvd   <= 1'b0;
      shut_bits <= 2'h0;
    end else if (wr_ok && wr_idx == bafe_pkg::IDX_CTRL_ONE) begin
      adc_en    <= wbyte[bafe_pkg::C1_ADC];
      temp_sel  <= wbyte[bafe_pkg::C1_TEMP];
      c1_rsvd   <= wbyte[bafe_pkg::C1_RSVD];
      shut_bits <= {wbyte[bafe_pkg::C1_SHUT_A], wbyte[bafe_pkg::C1_SHUT_B]};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      load_present <= 1'b0;
    end else begin
      load_present <= charge_pin_above_load && !charge_driver_on;
    end
  end

  // Shutdown sequence; any stray control one write spoils it until 00 is written again
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shut_state       <= bafe_pkg::BAFE_SHUT_START;
      shutdown_request <= 1'b0;
    end else begin
      shutdown_request <= 1'b0;
      if (wr_ok && wr_idx == bafe_pkg::IDX_CTRL_ONE) begin
        case ({wbyte[bafe_pkg::C1_SHUT_A], wbyte[bafe_pkg::C1_SHUT_B]})
          2'h0: shut_state <= bafe_pkg::BAFE_SHUT_START;
          2'h1: shut_state <= (shut_state == bafe_pkg::BAFE_SHUT_START) ?
                              bafe_pkg::BAFE_SHUT_ARMED : bafe_pkg::BAFE_SHUT_IGNORED;
          2'h2: begin
            shutdown_request <= (shut_state == bafe_pkg::BAFE_SHUT_ARMED);
            shut_state       <= bafe_pkg::BAFE_SHUT_IGNORED;
          end
          default: shut_state <= bafe_pkg::BAFE_SHUT_IGNORED;
        endcase
      end
    end
  end

  // Control two, except the single trigger
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      delay_bypass  <= 1'b0;
      cc_continuous <= 1'b0;
      c2_rsvd       <= 3'h0;
      discharge_driver_on        <= 1'b0;
      charge_driver_on        <= 1'b0;
    end else if (wr_ok && wr_idx == bafe_pkg::IDX_CTRL_TWO) begin
      delay_bypass  <= wbyte[bafe_pkg::C2_BYPASS];
      cc_continuous <= wbyte[bafe_pkg::C2_CONT];
      c2_rsvd       <= wbyte[bafe_pkg::C2_RSVD_HI:bafe_pkg::C2_RSVD_LO];
      discharge_driver_on        <= wbyte[bafe_pkg::C2_DSG];
      charge_driver_on        <= wbyte[bafe_pkg::C2_CHG];
    end
  end

  // Single trigger; a trigger left set under continuous mode waits for it to end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cc_trigger <= 1'b0;
    end else if (cc_done && !cc_continuous) begin
      cc_trigger <= 1'b0;
    end else if (wr_ok && wr_idx == bafe_pkg::IDX_CTRL_TWO && wbyte[bafe_pkg::C2_SINGLE] &&
                 !wbyte[bafe_pkg::C2_CONT] && !cc_continuous && !status[bafe_pkg::ST_READY]) begin
      cc_trigger <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !cc_run) begin
      cc_count <= '0;
    end else if (cc_done) begin
      cc_count <= '0;
    end else begin
      cc_count <= cc_count + CNT_W'(1);
    end
  end

  // Registered outputs and decoded protection settings
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cell_balance_enable        <= '0;
      conversions_enable         <= 1'b0;
      overvoltage_protect_enable <= 1'b0;
      temp_source_thermistor     <= 1'b0;
      counter_active             <= 1'b0;
      discharge_driver_output    <= 1'b0;
      charge_driver_output       <= 1'b0;
      threshold_range_select     <= 1'b0;
      short_circuit_delay_us     <= bafe_pkg::SC_DELAY_US[0];
      short_circuit_threshold_mv <= bafe_pkg::SC_LOWER_MV[0];
      overcurrent_delay_ms       <= bafe_pkg::OC_DELAY_MS[0];
      overcurrent_threshold_mv   <= bafe_pkg::OC_LOWER_MV[0];
    end else begin
      cell_balance_enable        <= {bal_high, bal_mid, bal_low};
      conversions_enable         <= adc_en;
      overvoltage_protect_enable <= adc_en;
      temp_source_thermistor     <= temp_sel;
      counter_active             <= cc_run;
      discharge_driver_output    <= discharge_driver_on;
      charge_driver_output       <= charge_driver_on;
      threshold_range_select     <= sc_prot[bafe_pkg::P1_RANGE];
      short_circuit_delay_us     <= delay_bypass ? bafe_pkg::BYPASS_DELAY_US :
        bafe_pkg::SC_DELAY_US[sc_prot[bafe_pkg::P1_SCD_HI:bafe_pkg::P1_SCD_LO]];
      short_circuit_threshold_mv <= sc_prot[bafe_pkg::P1_RANGE] ?
        bafe_pkg::SC_UPPER_MV[sc_prot[bafe_pkg::P1_SCT_HI:0]] :
        bafe_pkg::SC_LOWER_MV[sc_prot[bafe_pkg::P1_SCT_HI:0]];
      overcurrent_delay_ms       <= delay_bypass ? bafe_pkg::BYPASS_DELAY_MS :
        bafe_pkg::OC_DELAY_MS[oc_prot[bafe_pkg::P2_OCD_HI:bafe_pkg::P2_OCD_LO]];
      overcurrent_threshold_mv   <= sc_prot[bafe_pkg::P1_RANGE] ?
        bafe_pkg::OC_UPPER_MV[oc_prot[bafe_pkg::P2_OCT_HI:0]] :
        bafe_pkg::OC_LOWER_MV[oc_prot[bafe_pkg::P2_OCT_HI:0]];
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  w1c_clear_a: assert property (
    (wr_ok && wr_idx == bafe_pkg::IDX_STATUS && wbyte[bafe_pkg::ST_OC] && !overcurrent_event)
    |=> !status[bafe_pkg::ST_OC]) else $error("overcurrent flag not cleared by write one");

  ready_sticky_a: assert property (
    (status[bafe_pkg::ST_READY] && !(wr_ok && wr_idx == bafe_pkg::IDX_STATUS &&
     wbyte[bafe_pkg::ST_READY])) |=> status[bafe_pkg::ST_READY])
    else $error("result ready flag dropped without host clear");

  fault_latch_a: assert property (
    internal_fault_event |=> status[bafe_pkg::ST_FAULT]) else $error("internal fault not latched");

  alert_detect_a: assert property (
    $rose(status[bafe_pkg::ST_ALERT]) |-> $past(alert_pin_level && !alert_self_drive))
    else $error("alert override set without external pull-up");

  ov_gate_a: assert property (
    $rose(status[bafe_pkg::ST_OV]) |-> $past(overvoltage_event && adc_en))
    else $error("overvoltage latched while conversions disabled");

  load_detect_a: assert property (
    (charge_pin_above_load && !charge_driver_on) ##1 (charge_pin_above_load && !charge_driver_on) |-> load_present)
    else $error("load present not reported");

  shutdown_seq_a: assert property (
    shutdown_request |-> $past(shut_state == bafe_pkg::BAFE_SHUT_ARMED && wr_ok))
    else $error("shutdown without armed sequence");

  oneshot_done_a: assert property (
    ($fell(cc_trigger) && !cc_continuous) |-> status[bafe_pkg::ST_READY] ##1 !counter_active)
    else $error("single run end did not set ready and stop");

  trigger_gate_a: assert property (
    $rose(cc_trigger) |-> $past(!status[bafe_pkg::ST_READY] && !cc_continuous))
    else $error("trigger accepted while busy or ready set");

  bypass_delay_a: assert property (
    delay_bypass |=> overcurrent_delay_ms == bafe_pkg::BYPASS_DELAY_MS)
    else $error("delay bypass not applied");

  driver_follow_a: assert property (
    (wr_ok && wr_idx == bafe_pkg::IDX_CTRL_TWO) |->
      ##2 discharge_driver_output == $past(wbyte[bafe_pkg::C2_DSG], 2))
    else $error("discharge driver does not follow control");

  reserved_zero_a: assert property (
    (rvalid && rresp == bafe_pkg::RESP_OKAY) |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  shutdown_c: cover property (shutdown_request);
  oneshot_c: cover property ($fell(cc_trigger));
  clear_race_c: cover property (wr_ok && wr_idx == bafe_pkg::IDX_STATUS && overcurrent_event);

endmodule : bafe_regs

//--- bafe_regs_tb.sv
// Self-checking bench for the battery front end register bank
`timescale 1ns/1ps
module bafe_regs_tb;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr, araddr, d, e, st;
  logic [31:0] wdata, rdata, rv;
  logic [31:0] seed = 32'hCA95625F;
  logic [27:0] sq = 28'h1988786;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
  logic        rvalid, rready, shutdown_request, counter_active, threshold_range_select;
  logic        conversions_enable, overvoltage_protect_enable, temp_source_thermistor;
  logic        discharge_driver_output, charge_driver_output;
  logic        alert_pin_level = 1'b0;
  logic        alert_self_drive = 1'b0;
  logic        charge_pin_above_load = 1'b0;
  logic [4:0]  ev = 5'h00;
  logic [14:0] cell_balance_enable;
  logic [17:0] short_circuit_delay_us;
  logic [10:0] overcurrent_delay_ms;
  logic [7:0]  short_circuit_threshold_mv, overcurrent_threshold_mv;
  int          bad_count = 0;
  int          checks = 0;
  int          shut_n = 0;
  bafe_regs #(.CC_PERIOD_CYCLES(20)) dut (.*, .internal_fault_event(ev[4]),
    .undervoltage_event(ev[3]), .overvoltage_event(ev[2]), .short_circuit_event(ev[1]),
    .overcurrent_event(ev[0]));
  bafe_host h (.*);
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction : rnd
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Half-cycle pause lets registered outputs settle before sampling
  task automatic w(input logic [7:0] a, v);
    h.wr(a, v, rr);
    @(negedge aclk);
  endtask : w
  task automatic rc(input logic [7:0] a, v);
    h.rd(a, rv, rr);
    cmp(rv, {24'h0, v});
  endtask : rc
  task automatic pulse(input int i);
    @(posedge aclk);
    ev[i] <= 1'b1;
    @(posedge aclk);
    ev[i] <= 1'b0;
  endtask : pulse
  task automatic complete_run();
    bad_count += h.hangs;
    if (bad_count == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : complete_run
  initial forever #50 aclk = ~aclk;
  always @(posedge aclk) if (shutdown_request === 1'b1) shut_n++;
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    cmp({short_circuit_delay_us, overcurrent_delay_ms}, {18'h46, 11'h8});
    cmp({short_circuit_threshold_mv, overcurrent_threshold_mv}, 16'h1608);
    for (int i = 0; i < 8; i++) rc(8'(i * 4), 8'h00);
    for (int i = 1; i < 4; i++) begin
      d = rnd();
      w(8'(i * 4), d);
      rc(8'(i * 4), d & 8'h1F);
      cmp(cell_balance_enable[(i - 1) * 5 +: 5], d[4:0]);
    end
    pulse(2);
    rc(8'h00, 8'h00);
    w(8'h10, 8'h18);
    cmp({conversions_enable, overvoltage_protect_enable, temp_source_thermistor}, 3'h7);
    st = 8'h00;
    for (int i = 0; i < 5; i++) begin
      pulse(i);
      st = st | (i == 4 ? 8'h20 : 8'h01 << i);
      rc(8'h00, st);
    end
    alert_self_drive <= 1'b1;
    alert_pin_level <= 1'b1;
    rc(8'h00, 8'h2F);
    alert_self_drive <= 1'b0;
    rc(8'h00, 8'h3F);
    alert_pin_level <= 1'b0;
    w(8'h00, 8'h00);
    rc(8'h00, 8'h3F);
    w(8'h00, 8'h05);
    rc(8'h00, 8'h3A);
    w(8'h00, 8'hFF);
    rc(8'h00, 8'h00);
    repeat (8) begin
      d = rnd();
      e = rnd();
      w(8'h18, d);
      w(8'h1C, e);
      w(8'h14, {d[0], 5'h00, e[1:0]});
      rc(8'h18, d & 8'h9F);
      rc(8'h1C, e & 8'h7F);
      cmp({discharge_driver_output, charge_driver_output}, e[1:0]);
      cmp(threshold_range_select, d[7]);
      cmp(short_circuit_delay_us, d[0] ? 18'h3D090 : d[4:3] ? 18'h32 << d[4:3] : 18'h46);
      cmp(overcurrent_delay_ms, d[0] ? 11'hFA : e[6:4] ? 11'hA << e[6:4] : 11'h8);
      cmp(short_circuit_threshold_mv, d[7] ? bafe_pkg::SC_UPPER_MV[d[2:0]]
          : bafe_pkg::SC_LOWER_MV[d[2:0]]);
      cmp(overcurrent_threshold_mv, d[7] ? bafe_pkg::OC_UPPER_MV[e[3:0]]
          : bafe_pkg::OC_LOWER_MV[e[3:0]]);
    end
    w(8'h14, 8'h01);
    charge_pin_above_load <= 1'b1;
    rc(8'h10, 8'h18);
    w(8'h14, 8'h00);
    rc(8'h10, 8'h98);
    charge_pin_above_load <= 1'b0;
    rc(8'h10, 8'h18);
    for (int k = 13; k >= 0; k--) w(8'h10, {6'h06, sq[2 * k +: 2]});
    cmp(shut_n, 32'h2);
    w(8'h14, 8'h20);
    cmp(counter_active, 1'b1);
    repeat (25) @(posedge aclk);
    cmp(counter_active, 1'b0);
    rc(8'h14, 8'h00);
    rc(8'h00, 8'h80);
    w(8'h14, 8'h20);
    rc(8'h14, 8'h00);
    w(8'h00, 8'h80);
    w(8'h14, 8'h60);
    rc(8'h14, 8'h40);
    repeat (50) @(posedge aclk);
    rc(8'h00, 8'h80);
    cmp(counter_active, 1'b1);
    h.wr(8'h20, 8'hFF, rr);
    cmp(rr, 2'h2);
    h.rd(8'h1D, rv, rr);
    cmp({rv[29:0], rr}, 32'h2);
    complete_run();
  end
endmodule : bafe_regs_tb
